// ==== hdl/csf_defines.vh ====
// constants for the status-flag and arithmetic block
`ifndef CSF_DEFINES_VH
`define CSF_DEFINES_VH
// status word bit positions
`define CSF_BIT_C      0
`define CSF_BIT_Z      1
`define CSF_BIT_I      2
`define CSF_BIT_D      3
`define CSF_BIT_B      4
`define CSF_BIT_T      5
`define CSF_BIT_V      6
`define CSF_BIT_N      7
// reset value of the status word: only the interrupt mask is defined
`define CSF_PS_RESET   8'h04
// operation codes on op_code
`define CSF_OP_NONE    4'h0
`define CSF_OP_ADC     4'h1
`define CSF_OP_SBC     4'h2
`define CSF_OP_SEC     4'h3
`define CSF_OP_CLC     4'h4
`define CSF_OP_SED     4'h5
`define CSF_OP_CLD     4'h6
`define CSF_OP_PUSH    4'h7
`define CSF_OP_PULL    4'h8
`define CSF_OP_MUL     4'h9
`define CSF_OP_DIV     4'hA
`define CSF_OP_BRK     4'hB
`define CSF_OP_SEI     4'hC
`define CSF_OP_CLI     4'hD
`define CSF_OP_DIRW    4'hE
`define CSF_OP_DIRR    4'hF
// register map over the bus (word offsets in bytes)
`define CSF_REG_CMD    4'h0
`define CSF_REG_ACC    4'h4
`define CSF_REG_OPND   4'h8
`define CSF_REG_PS     4'hC
`define CSF_ADDR_W     4
`endif

// ==== hdl/csf_core.v ====
// status word, decimal arithmetic, multiply/divide and direction-register model
// Summary of operation
// - Reset sets the interrupt mask to one; other status bits are don't-care.
// - Push-status stores the status word at stack pointer plus one; pull restores.
// - Break with mask set and a pending enabled source vectors to highest priority.
// - Only add and subtract give decimal results when the decimal flag is one.
// - In decimal mode N, V and Z after add or subtract are undefined.
// - Decimal carry flag is one on carry, zero on borrow.
// - Multiply and divide ignore the X-mode and decimal flags.
// - Multiply and divide leave the status word unchanged.
// - Direction registers are write-only; reads do not return stored value.
`timescale 1ns/100ps
`default_nettype none
`include "csf_defines.vh"
module csf_core #(
    parameter NSRC = 8
) (
    // clock and reset
    input  wire             mclk,
    input  wire             rst_b,
    // avalon-mm slave
    input  wire [3:0]       avs_address,
    input  wire             avs_read,
    input  wire             avs_write,
    input  wire [31:0]      avs_writedata,
    output reg  [31:0]      avs_readdata,
    output wire             avs_waitrequest,
    // interrupt sources
    input  wire [NSRC-1:0]  irq_request,
    input  wire [NSRC-1:0]  irq_enable,
    // break vectoring result, stack pointer and byte, direction register
    output reg              brk_taken,
    output reg  [7:0]       brk_vector,
    output reg  [7:0]       stack_pointer,
    output reg  [7:0]       stack_byte,
    output reg  [7:0]       direction_reg
);
    reg  [7:0]  processor_status_word;
    reg  [7:0]  acc;
    reg  [7:0]  opnd;
    reg  [7:0]  hi;
    reg         ack;
    reg  [7:0]  next_ps;
    reg  [7:0]  next_acc;
    reg  [7:0]  next_hi;
    reg  [4:0]  lo_sum;
    reg  [4:0]  hi_sum;
    reg  [8:0]  bin;
    reg         lo_c;
    reg  [15:0] prod;
    reg  [7:0]  vec;
    reg         found;
    integer     k;

    wire        wr_cmd = avs_write & ~ack & (avs_address == `CSF_REG_CMD);
    wire [3:0]  op     = avs_writedata[3:0];
    wire        dec    = processor_status_word[`CSF_BIT_D];
    wire        cin    = processor_status_word[`CSF_BIT_C];
    // one wait state on every access keeps the answer registered
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;

    // sources are levels from logic on this clock, so no synchroniser is used

    // lowest-numbered pending enabled source is highest priority
    always @* begin
        vec   = 8'h00;
        found = 1'b0;
        for (k = NSRC - 1; k >= 0; k = k - 1) begin
            if (irq_request[k] & irq_enable[k]) begin
                vec   = k[7:0];
                found = 1'b1;
            end
        end
    end

    // next values only take effect on a taken command write
    always @* begin
        next_ps  = processor_status_word;
        next_acc = acc;
        next_hi  = hi;
        lo_sum   = 5'h00;
        hi_sum   = 5'h00;
        lo_c     = 1'b0;
        bin      = 9'h000;
        prod     = 16'h0000;
        case (op)
            `CSF_OP_ADC: begin
                if (dec) begin
                    lo_sum = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
                    lo_c   = (lo_sum > 5'h09);
                    if (lo_c)
                        lo_sum = lo_sum + 5'h06;
                    hi_sum = {1'b0, acc[7:4]} + {1'b0, opnd[7:4]} + {4'h0, lo_c};
                    next_ps[`CSF_BIT_C] = (hi_sum > 5'h09);
                    if (hi_sum > 5'h09)
                        hi_sum = hi_sum + 5'h06;
                    next_acc = {hi_sum[3:0], lo_sum[3:0]};
                    // N, V, Z left as they were
                end else begin
                    bin = {1'b0, acc} + {1'b0, opnd} + {8'h00, cin};
                    next_acc = bin[7:0];
                    next_ps[`CSF_BIT_C] = bin[8];
                    next_ps[`CSF_BIT_Z] = (bin[7:0] == 8'h00);
                    next_ps[`CSF_BIT_N] = bin[7];
                    next_ps[`CSF_BIT_V] = (acc[7] == opnd[7]) & (bin[7] != acc[7]);
                end
            end
            `CSF_OP_SBC: begin
                if (dec) begin
                    lo_sum = {1'b0, acc[3:0]} - {1'b0, opnd[3:0]} - {4'h0, ~cin};
                    lo_c   = lo_sum[4];
                    if (lo_c)
                        lo_sum = lo_sum - 5'h06;
                    hi_sum = {1'b0, acc[7:4]} - {1'b0, opnd[7:4]} - {4'h0, lo_c};
                    next_ps[`CSF_BIT_C] = ~hi_sum[4];
                    if (hi_sum[4])
                        hi_sum = hi_sum - 5'h06;
                    next_acc = {hi_sum[3:0], lo_sum[3:0]};
                    // N, V, Z left as they were
                end else begin
                    bin = {1'b0, acc} - {1'b0, opnd} - {8'h00, ~cin};
                    next_acc = bin[7:0];
                    next_ps[`CSF_BIT_C] = ~bin[8];
                    next_ps[`CSF_BIT_Z] = (bin[7:0] == 8'h00);
                    next_ps[`CSF_BIT_N] = bin[7];
                    next_ps[`CSF_BIT_V] = (acc[7] != opnd[7]) & (bin[7] != acc[7]);
                end
            end
            // flag ops act at once; spacing after decimal math is left to software
            `CSF_OP_SEC: next_ps[`CSF_BIT_C] = 1'b1;
            `CSF_OP_CLC: next_ps[`CSF_BIT_C] = 1'b0;
            `CSF_OP_SED: next_ps[`CSF_BIT_D] = 1'b1;
            `CSF_OP_CLD: next_ps[`CSF_BIT_D] = 1'b0;
            `CSF_OP_SEI: next_ps[`CSF_BIT_I] = 1'b1;
            `CSF_OP_CLI: next_ps[`CSF_BIT_I] = 1'b0;
            `CSF_OP_PULL: next_ps = stack_byte;
            `CSF_OP_MUL: begin
                // flags neither read nor written
                prod     = acc * opnd;
                next_acc = prod[7:0];
                next_hi  = prod[15:8];
            end
            `CSF_OP_DIV: begin
                // divide by zero yields an all-ones quotient and the dividend as remainder, a choice of this block
                if (opnd != 8'h00) begin
                    next_acc = acc / opnd;
                    next_hi  = acc % opnd;
                end else begin
                    next_acc = 8'hFF;
                    next_hi  = acc;
                end
            end
            `CSF_OP_BRK: next_ps[`CSF_BIT_I] = 1'b1;
            default: next_ps = processor_status_word;
        endcase
    end

    always @(posedge mclk) begin
        if (!rst_b) begin
            // only the mask is defined after reset; other bits zero by choice
            processor_status_word <= `CSF_PS_RESET;
            acc           <= 8'h00;
            opnd          <= 8'h00;
            hi            <= 8'h00;
            ack           <= 1'b0;
            avs_readdata  <= 32'h00000000;
            brk_taken     <= 1'b0;
            brk_vector    <= 8'h00;
            stack_pointer <= 8'hFF;
            stack_byte    <= 8'h00;
            direction_reg <= 8'h00;
        end else begin
            // ack marks the second cycle, so a request is taken once per two-cycle access; one held longer is taken again every second cycle
            ack <= (avs_read | avs_write) & ~ack;

            // direction register has no read path; its offset stays unmapped
            if (avs_read & ~ack) begin
                case (avs_address)
                    `CSF_REG_CMD:  avs_readdata <= {23'h000000, brk_taken, brk_vector};
                    `CSF_REG_ACC:  avs_readdata <= {16'h0000, hi, acc};
                    `CSF_REG_OPND: avs_readdata <= {24'h000000, opnd};
                    `CSF_REG_PS:   avs_readdata <= {16'h0000, stack_pointer, stack_byte};
                    default:       avs_readdata <= 32'h00000000;
                endcase
            end
            if (avs_write & ~ack & (avs_address == `CSF_REG_ACC))
                acc <= avs_writedata[7:0];
            if (avs_write & ~ack & (avs_address == `CSF_REG_OPND))
                opnd <= avs_writedata[7:0];

            // status word moves only here, so multiply and divide keep it intact
            if (wr_cmd) begin
                processor_status_word <= next_ps;
                acc <= next_acc;
                hi  <= next_hi;
                if (op == `CSF_OP_PUSH) begin
                    // byte lands at sp, so after the decrement it sits at sp+1
                    stack_byte    <= processor_status_word;
                    stack_pointer <= stack_pointer - 8'h01;
                end
                if (op == `CSF_OP_PULL)
                    stack_pointer <= stack_pointer + 8'h01;

                // without mask or pending source the flag drops; vector shows FF only when no enabled source is pending
                if (op == `CSF_OP_BRK) begin
                    brk_taken  <= found & processor_status_word[`CSF_BIT_I];
                    brk_vector <= found ? vec : 8'hFF;
                end

                // write-only: no read path exists
                if (op == `CSF_OP_DIRW)
                    direction_reg <= avs_writedata[15:8];
            end
        end
    end
endmodule // csf_core
`default_nettype wire

// ==== sim/csf_core_asserts.sv ====
// port-level checker for the status-flag block
`timescale 1ns/100ps
`default_nettype none
module csf_core_asserts #(
    parameter NSRC = 8
) (
    // clock and reset
    input wire logic            mclk,
    input wire logic            rst_b,
    // register bus
    input wire logic [3:0]      avs_address,
    input wire logic            avs_read,
    input wire logic            avs_write,
    input wire logic [31:0]     avs_writedata,
    input wire logic [31:0]     avs_readdata,
    input wire logic            avs_waitrequest,
    // sources and results
    input wire logic [NSRC-1:0] irq_request,
    input wire logic [NSRC-1:0] irq_enable,
    input wire logic            brk_taken,
    input wire logic [7:0]      brk_vector,
    input wire logic [7:0]      stack_pointer,
    input wire logic [7:0]      stack_byte,
    input wire logic [7:0]      direction_reg
);
    logic cmdw;
    logic rdone;
    assign cmdw = avs_write && avs_address == 4'h0;
    assign rdone = avs_read && !avs_waitrequest;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    AST_RST: assert property ($rose(rst_b) |-> stack_pointer == 8'hFF && !brk_taken)
        else $error("reset state wrong");
    AST_WAIT: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("waitrequest timing wrong");
    AST_PS_RD: assert property (rdone && avs_address == 4'hC |-> avs_readdata[15:0] == {stack_pointer, stack_byte})
        else $error("stack read wrong");
    AST_BRK_RD: assert property (rdone && avs_address == 4'h0 |-> avs_readdata[8:0] == {brk_taken, brk_vector})
        else $error("break read wrong");
    AST_UNMAP: assert property (rdone && avs_address[1:0] != 2'b00 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_BRK_VEC: assert property (brk_taken |-> brk_vector != 8'hFF)
        else $error("break taken without source");
    AST_SP: assert property ($changed(stack_pointer) |-> $past(cmdw))
        else $error("stack pointer moved alone");
    AST_SB: assert property ($changed(stack_byte) |-> $past(cmdw && avs_writedata[3:0] == 4'h7))
        else $error("stack byte moved without push");
    AST_DIR: assert property ($changed(direction_reg) |-> $past(cmdw && avs_writedata[3:0] == 4'hE))
        else $error("direction moved without write");
    AST_BTK: assert property ($changed(brk_taken) |-> $past(cmdw && avs_writedata[3:0] == 4'hB))
        else $error("break flag moved alone");
    cover property (brk_taken);
    cover property (cmdw && avs_writedata[3:0] == 4'h7);
    cover property (rdone && avs_address == 4'h2);
endmodule // csf_core_asserts
bind csf_core csf_core_asserts #(.NSRC(NSRC)) i_chk (.mclk(mclk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_request(irq_request), .irq_enable(irq_enable),
    .brk_taken(brk_taken), .brk_vector(brk_vector), .stack_pointer(stack_pointer),
    .stack_byte(stack_byte), .direction_reg(direction_reg));
`default_nettype wire

// ==== sim/tb_cpu_status_flag_rules.sv ====
// self-checking bench for the status-flag block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module tb_cpu_status_flag_rules;
    logic        mclk, rst_b, avs_read, avs_write, avs_waitrequest, brk_taken;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [7:0]  irq_request, irq_enable, brk_vector, stack_pointer, stack_byte, direction_reg;
    logic [7:0]  ps, p;
    int          n_mismatch = 0;
    int          comparisons = 0;
    csf_core #(.NSRC(8)) i_dut (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq_request(irq_request), .irq_enable(irq_enable), .brk_taken(brk_taken),
        .brk_vector(brk_vector), .stack_pointer(stack_pointer), .stack_byte(stack_byte),
        .direction_reg(direction_reg));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic close_out;
        if (n_mismatch == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // waitrequest and read data taken at the rising edge; request released only after it
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        if (n >= 20) begin
            n_mismatch++;
            close_out();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic op(input logic [3:0] c);
        bus(1'b1, 4'h0, {28'h0, c});
    endtask
    // status word only shows through a push and the stack byte
    task automatic status;
        op(4'h7);
        bus(1'b0, 4'hC, 32'h0);
        ps = q[7:0];
    endtask
    task automatic arith(input logic [3:0] c, input logic [7:0] a, b, r, input logic cy);
        bus(1'b1, 4'h4, {24'h0, a});
        bus(1'b1, 4'h8, {24'h0, b});
        op(c);
        status();
        `CHK(ps[0], cy)
        bus(1'b0, 4'h4, 32'h0);
        `CHK(q[7:0], r)
    endtask
    task automatic t_reset;
        status();
        `CHK(ps[2], 1'b1)
        `CHK(q[15:8], 8'hFE)
    endtask
    // push inside arith is the spacing instruction before the next flag op
    task automatic t_decimal;
        op(4'h6);
        op(4'h4);
        arith(4'h1, 8'h38, 8'h47, 8'h7F, 1'b0);
        op(4'h5);
        op(4'h4);
        arith(4'h1, 8'h38, 8'h47, 8'h85, 1'b0);
        op(4'h4);
        arith(4'h1, 8'h99, 8'h01, 8'h00, 1'b1);
        op(4'h3);
        arith(4'h2, 8'h20, 8'h01, 8'h19, 1'b1);
        op(4'h3);
        arith(4'h2, 8'h00, 8'h01, 8'h99, 1'b0);
    endtask
    task automatic t_muldiv;
        op(4'h3);
        status();
        p = ps;
        bus(1'b1, 4'h4, 32'h12);
        bus(1'b1, 4'h8, 32'h10);
        op(4'h9);
        bus(1'b0, 4'h4, 32'h0);
        `CHK(q[15:0], 16'h0120)
        status();
        `CHK(ps, p)
        bus(1'b1, 4'h4, 32'h37);
        bus(1'b1, 4'h8, 32'h0);
        op(4'hA);
        bus(1'b0, 4'h4, 32'h0);
        `CHK(q[15:0], 16'h37FF)
        status();
        `CHK(ps, p)
    endtask
    task automatic t_brk;
        irq_request <= 8'h28;
        irq_enable <= 8'h24;
        op(4'hC);
        op(4'hB);
        bus(1'b0, 4'h0, 32'h0);
        `CHK(q[8:0], 9'h105)
        irq_enable <= 8'h00;
        op(4'hB);
        bus(1'b0, 4'h0, 32'h0);
        `CHK(q[8:0], 9'h0FF)
    endtask
    // no indirect jump exists on this bus, so no pointer is ever placed
    task automatic t_dir;
        bus(1'b1, 4'h0, 32'hA50E);
        `CHK(direction_reg, 8'hA5)
        bus(1'b1, 4'h2, 32'hFF);
        bus(1'b0, 4'h2, 32'h0);
        `CHK(q, 32'h0)
        `CHK(direction_reg, 8'hA5)
    endtask
    initial begin
        {rst_b, avs_read, avs_write, avs_address, avs_writedata} = '0;
        irq_request = 8'h00;
        irq_enable = 8'h00;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset();
        t_decimal();
        t_muldiv();
        t_brk();
        t_dir();
        close_out();
    end
endmodule // tb_cpu_status_flag_rules
`default_nettype wire
